// >>> logic/lcdcd_map.svh
// Functional notes
// - Commands E4/E5 turn n-line inverting drive off/on via bit 0.
// - Command 66 takes a parameter: bit0 gray/binary, bit1 dummy level; reset zero.
// - Dummy period drives segments lit when dummy bit 0, unlit when 1.
// - Command 39 stores gray levels: bits 6-4 for (1,0), bits 2-0 for (0,1).
// - Line count code selects 5 plus 4 times code display lines.
// - Duty is one over line count plus seven.
// - Line count code resets to 10011; codes 14H or above are refused.
// - Start block picks one of 20 four-line groups, mirrored in reverse scan.
// - Start block resets to zero; codes 14H or above are refused.
// - Scan runs from start block, wraps after top line, extra line last.
// - Command E0 enters read-modify-write; reads hold column, writes advance.
// - End command leaves the mode and restores the saved column address.
// - Read-modify-write is inactive after reset.
// - AA/AB stop/start oscillator only as master with internal oscillator; off at reset.
// - Command 5F takes a 4-bit oscillator frequency code; zero at reset.
// - Command 25 takes a parameter with upper five bits zero, low three enables.
// - Power bits: 2 step-up, 1 V3 adjust, 0 drive voltage; all clear at reset.
`ifndef LCDCD_MAP_SVH
`define LCDCD_MAP_SVH
`define LCDCD_CMD_INV_OFF   8'hE4
`define LCDCD_CMD_INV_ON    8'hE5
`define LCDCD_CMD_MODE      8'h66
`define LCDCD_CMD_GRAY      8'h39
`define LCDCD_CMD_LINES     8'h6D
`define LCDCD_CMD_RMW       8'hE0
`define LCDCD_CMD_END       8'hEE
`define LCDCD_CMD_OSC_OFF   8'hAA
`define LCDCD_CMD_OSC_ON    8'hAB
`define LCDCD_CMD_FREQ      8'h5F
`define LCDCD_CMD_POWER     8'h25
`define LCDCD_CMD_COL_SET   8'h13
`define LCDCD_LINE_RST      5'h13
`define LCDCD_LINES_RST     7'h51
`define LCDCD_DUTY_RST      7'h58
`define LCDCD_LINE_LIMIT    5'h14
`define LCDCD_BLOCK_RST     5'h00
`define LCDCD_BLOCK_TOP     5'h13
`define LCDCD_LINES_BASE    7'h05
`define LCDCD_DUTY_ADD      7'h07
`define LCDCD_GRAY_RST      7'h00
`define LCDCD_POWER_MASK    8'hF8
`define LCDCD_COM_TOP       7'h4F
`define LCDCD_COM_LAST      7'h50
`endif

// >>> logic/lcdcd_pkg.sv
package lcdcd_pkg;
    // Parameter collection state after a command byte.
    typedef enum logic [2:0] {
        LCDCD_IDLE   = 3'b000,
        LCDCD_P_MODE = 3'b001,
        LCDCD_P_GRAY = 3'b011,
        LCDCD_P_LINE = 3'b010,
        LCDCD_P_BLK  = 3'b110,
        LCDCD_P_FREQ = 3'b111,
        LCDCD_P_PWR  = 3'b101
    } lcdcd_state_t;

    // One host bus write.
    typedef struct packed {
        logic       strobe;
        logic       is_data;
        logic [7:0] value;
    } lcdcd_host_wr_t;

    // Display configuration held by the decoder.
    typedef struct packed {
        logic       inv_on;
        logic       binary_mode;
        logic       dummy_unlit;
        logic [2:0] gray_one_zero;
        logic [2:0] gray_zero_one;
        logic [4:0] line_code;
        logic [4:0] start_block;
        logic       osc_on;
        logic [3:0] osc_freq;
        logic [2:0] power_en;
    } lcdcd_cfg_t;

    // Display data access events from the RAM port.
    typedef struct packed {
        logic       rd;
        logic       wr;
    } lcdcd_ram_acc_t;
endpackage : lcdcd_pkg

// >>> logic/lcdcd_top.sv
`timescale 1ns/100ps
`include "lcdcd_map.svh"
module lcdcd_top
(
    input  wire logic                     i_clk,
    input  wire logic                     i_srst,
    input  wire lcdcd_pkg::lcdcd_host_wr_t i_host,
    input  wire lcdcd_pkg::lcdcd_ram_acc_t i_ram,
    input  wire logic                     i_master_strap,
    input  wire logic                     i_internal_osc_select_strap,
    input  wire logic                     i_scan_reverse,
    input  wire logic                     i_dummy_period,
    input  wire logic                     i_line_step,
    input  wire logic                     i_col_load,
    input  wire logic [7:0]               i_col_value,
    output lcdcd_pkg::lcdcd_cfg_t         o_cfg,
    output logic [6:0]                    o_display_lines,
    output logic [6:0]                    o_duty_div,
    output logic                          o_rmw_active,
    output logic [7:0]                    o_col_addr,
    output logic                          o_segment_force_unlit,
    output logic [6:0]                    o_common_line,
    output logic                          o_extra_common_line
);
    import lcdcd_pkg::*;

    // Command decoder state.
    lcdcd_state_t state;
    lcdcd_state_t next_state;
    lcdcd_cfg_t   next_cfg;
    logic         next_rmw;

    // Column save and column next value.
    logic [7:0]   col_save;
    logic [7:0]   next_col_save;
    logic [7:0]   next_col;

    // Derived display figures.
    logic [6:0]   next_lines;
    logic [6:0]   next_duty;
    logic         next_seg_unlit;

    // Common line scan position.
    logic [6:0]   line_pos;
    logic [6:0]   next_line_pos;
    logic [6:0]   next_common;
    logic         next_extra;

    // Translates a position in the frame into a physical common line.
    function automatic logic [6:0] lcdcd_com_of(input logic [4:0] blk,
                                                 input logic       rev,
                                                 input logic [6:0] pos);
        logic [6:0] base;
        logic [6:0] idx;
        base = {blk, 2'b00};
        idx  = base + pos;
        if (idx > `LCDCD_COM_TOP)
        begin
            idx = idx - `LCDCD_COM_LAST;
        end
        if (rev)
        begin
            lcdcd_com_of = `LCDCD_COM_TOP - idx;
        end
        else
        begin
            lcdcd_com_of = idx;
        end
    endfunction : lcdcd_com_of

    // True for a command byte on the host bus.
    function automatic logic lcdcd_is_cmd(input lcdcd_host_wr_t h);
        lcdcd_is_cmd = h.strobe && !h.is_data;
    endfunction : lcdcd_is_cmd

    // True for a parameter byte on the host bus.
    function automatic logic lcdcd_is_par(input lcdcd_host_wr_t h);
        lcdcd_is_par = h.strobe && h.is_data;
    endfunction : lcdcd_is_par

    // Line count and start block codes at or above the limit are refused.
    function automatic logic lcdcd_code_ok(input logic [4:0] code);
        lcdcd_code_ok = (code < `LCDCD_LINE_LIMIT);
    endfunction : lcdcd_code_ok

    // Command and parameter decoding.
    always_comb
    begin
        next_state = state;
        next_cfg   = o_cfg;
        next_rmw   = o_rmw_active;
        next_col_save = col_save;

        // A command byte ends any pending parameter collection.
        if (lcdcd_is_cmd(i_host))
        begin
            next_state = LCDCD_IDLE;
            case (i_host.value)
                `LCDCD_CMD_INV_OFF,
                `LCDCD_CMD_INV_ON:
                begin
                    next_cfg.inv_on = i_host.value[0];
                end
                `LCDCD_CMD_MODE:
                begin
                    next_state = LCDCD_P_MODE;
                end
                `LCDCD_CMD_GRAY:
                begin
                    next_state = LCDCD_P_GRAY;
                end
                `LCDCD_CMD_LINES:
                begin
                    next_state = LCDCD_P_LINE;
                end
                `LCDCD_CMD_FREQ:
                begin
                    next_state = LCDCD_P_FREQ;
                end
                `LCDCD_CMD_POWER:
                begin
                    next_state = LCDCD_P_PWR;
                end
                `LCDCD_CMD_RMW:
                begin
                    next_rmw      = 1'b1;
                    next_col_save = o_col_addr;
                end
                `LCDCD_CMD_END:
                begin
                    next_rmw = 1'b0;
                end
                `LCDCD_CMD_OSC_OFF,
                `LCDCD_CMD_OSC_ON:
                begin
                    if (i_master_strap && i_internal_osc_select_strap)
                    begin
                        next_cfg.osc_on = i_host.value[0];
                    end
                end
                default:
                begin
                    next_state = LCDCD_IDLE;
                end
            endcase
        end
        // A parameter byte lands in the setting that the last command opened.
        else if (lcdcd_is_par(i_host))
        begin
            next_state = LCDCD_IDLE;
            case (state)
                LCDCD_P_MODE:
                begin
                    next_cfg.binary_mode = i_host.value[0];
                    next_cfg.dummy_unlit = i_host.value[1];
                end
                LCDCD_P_GRAY:
                begin
                    next_cfg.gray_one_zero = i_host.value[6:4];
                    next_cfg.gray_zero_one = i_host.value[2:0];
                end
                LCDCD_P_LINE:
                begin
                    if (lcdcd_code_ok(i_host.value[4:0]))
                    begin
                        next_cfg.line_code = i_host.value[4:0];
                    end
                    next_state = LCDCD_P_BLK;
                end
                LCDCD_P_BLK:
                begin
                    if (lcdcd_code_ok(i_host.value[4:0]))
                    begin
                        next_cfg.start_block = i_host.value[4:0];
                    end
                end
                LCDCD_P_FREQ:
                begin
                    next_cfg.osc_freq = i_host.value[3:0];
                end
                LCDCD_P_PWR:
                begin
                    if ((i_host.value & `LCDCD_POWER_MASK) == 8'h00)
                    begin
                        next_cfg.power_en = i_host.value[2:0];
                    end
                end
                default:
                begin
                    next_state = LCDCD_IDLE;
                end
            endcase
        end
    end

    // Decoder state registers.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state        <= LCDCD_IDLE;
            o_cfg        <= '{inv_on:        1'b0,
                              binary_mode:   1'b0,
                              dummy_unlit:   1'b0,
                              gray_one_zero: 3'h0,
                              gray_zero_one: 3'h0,
                              line_code:     `LCDCD_LINE_RST,
                              start_block:   `LCDCD_BLOCK_RST,
                              osc_on:        1'b0,
                              osc_freq:      4'h0,
                              power_en:      3'h0};
            o_rmw_active <= 1'b0;
            col_save     <= 8'h00;
        end
        else
        begin
            state        <= next_state;
            o_cfg        <= next_cfg;
            o_rmw_active <= next_rmw;
            col_save     <= next_col_save;
        end
    end

    // Column address tracking and derived display figures.
    always_comb
    begin
        next_col = o_col_addr;
        // The end command restores the column saved on entry to the mode.
        if (lcdcd_is_cmd(i_host) && i_host.value == `LCDCD_CMD_END && o_rmw_active)
        begin
            next_col = col_save;
        end
        else if (i_col_load)
        begin
            next_col = i_col_value;
        end
        else if (i_ram.wr || (i_ram.rd && !o_rmw_active))
        begin
            next_col = o_col_addr + 8'h01;
        end
        // Derived figures follow the registered configuration.
        next_lines     = `LCDCD_LINES_BASE + {o_cfg.line_code, 2'b00};
        next_duty      = next_lines + `LCDCD_DUTY_ADD;
        next_seg_unlit = i_dummy_period && o_cfg.dummy_unlit;
    end

    // Column and derived output registers.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_col_addr            <= 8'h00;
            o_display_lines       <= `LCDCD_LINES_RST;
            o_duty_div            <= `LCDCD_DUTY_RST;
            o_segment_force_unlit <= 1'b0;
        end
        else
        begin
            o_col_addr            <= next_col;
            o_display_lines       <= next_lines;
            o_duty_div            <= next_duty;
            o_segment_force_unlit <= next_seg_unlit;
        end
    end

    // Common line scan across the frame, extra common line last.
    always_comb
    begin
        next_line_pos = line_pos;
        next_extra    = o_extra_common_line;
        next_common   = o_common_line;

        // The frame position wraps after its last line, the extra common line.
        if (i_line_step)
        begin
            if (line_pos + 7'h01 >= o_display_lines)
            begin
                next_line_pos = 7'h00;
            end
            else
            begin
                next_line_pos = line_pos + 7'h01;
            end
        end
        // The extra common line is the last position of every frame.
        next_extra  = (next_line_pos == o_display_lines - 7'h01);
        next_common = lcdcd_com_of(o_cfg.start_block, i_scan_reverse, next_line_pos);
    end

    // Scan registers.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            line_pos            <= 7'h00;
            o_common_line       <= 7'h00;
            o_extra_common_line <= 1'b0;
        end
        else
        begin
            line_pos            <= next_line_pos;
            o_common_line       <= next_common;
            o_extra_common_line <= next_extra;
        end
    end
endmodule : lcdcd_top

// >>> tb/lcdcd_host_model.sv
`timescale 1ns/100ps
module lcdcd_host_model
(
    input  wire logic                 i_clk,
    output lcdcd_pkg::lcdcd_host_wr_t o_host
);
    import lcdcd_pkg::*;
    // The bus starts idle.
    initial o_host = '0;
    // One byte per strobe; the command/data select splits commands from parameters.
    task automatic send(input logic is_data, input logic [7:0] value);
        o_host = '{1'b1, is_data, value};
        @(posedge i_clk);
        #1;
    endtask : send
    // Strobe drops and the released lines turn over, so a stale byte never looks valid.
    task automatic idle_bus();
        o_host = '{1'b0, ~o_host.is_data, ~o_host.value};
        @(posedge i_clk);
        #1;
    endtask : idle_bus
    // A lone command byte.
    task automatic cmd(input logic [7:0] c);
        send(1'b0, c);
        idle_bus();
    endtask : cmd
    // A command with its single parameter right behind it.
    task automatic cmd_par(input logic [7:0] c, input logic [7:0] p);
        send(1'b0, c);
        send(1'b1, p);
        idle_bus();
    endtask : cmd_par
endmodule : lcdcd_host_model

// >>> tb/lcdcd_chk.sv
`timescale 1ns/100ps
module lcdcd_chk
(
    input wire logic                      i_clk,
    input wire logic                      i_srst,
    input wire lcdcd_pkg::lcdcd_host_wr_t i_host,
    input wire lcdcd_pkg::lcdcd_ram_acc_t i_ram,
    input wire logic                      i_dummy_period,
    input wire logic                      i_col_load,
    input wire lcdcd_pkg::lcdcd_cfg_t     o_cfg,
    input wire logic [6:0]                o_display_lines,
    input wire logic [6:0]                o_duty_div,
    input wire logic                      o_rmw_active,
    input wire logic [7:0]                o_col_addr,
    input wire logic                      o_segment_force_unlit
);
    import lcdcd_pkg::*;
    logic       cmd;
    logic       prm;
    logic [7:0] v;
    logic [7:0] saved;
    // Command and parameter strobes.
    assign cmd = i_host.strobe & ~i_host.is_data;
    assign prm = i_host.strobe & i_host.is_data;
    assign v = i_host.value;
    // Column held on entry to read-modify-write.
    always_ff @(posedge i_clk)
        if (cmd && v == 8'hE0)
            saved <= o_col_addr;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_par(c);
        cmd && v == c ##1 prm;
    endsequence
    property p_inv; cmd && v[7:1] == 7'h72 |=> o_cfg.inv_on == $past(v[0]); endproperty
    a_inv: assert property (p_inv) else $error("inversion flag wrong");
    property p_mode; s_par(8'h66) |=> {o_cfg.dummy_unlit, o_cfg.binary_mode} == $past(v[1:0]);
    endproperty
    a_mode: assert property (p_mode) else $error("display mode wrong");
    property p_seg; $stable(i_dummy_period) && $stable(o_cfg.dummy_unlit)
        |-> o_segment_force_unlit == (i_dummy_period && o_cfg.dummy_unlit); endproperty
    a_seg: assert property (p_seg) else $error("segment level wrong");
    property p_gray; s_par(8'h39)
        |=> {o_cfg.gray_one_zero, o_cfg.gray_zero_one} == $past({v[6:4], v[2:0]}); endproperty
    a_gray: assert property (p_gray) else $error("gray pattern wrong");
    property p_lines; $stable(o_cfg.line_code) [*2] |-> o_display_lines ==
        7'h05 + {o_cfg.line_code, 2'b00} && o_duty_div == o_display_lines + 7'h07; endproperty
    a_lines: assert property (p_lines) else $error("lines or duty wrong");
    property p_line; s_par(8'h6D) |=> o_cfg.line_code ==
        ($past(v[4:0]) < 5'h14 ? $past(v[4:0]) : $past(o_cfg.line_code)); endproperty
    a_line: assert property (p_line) else $error("line code wrong");
    property p_rd; o_rmw_active && i_ram == 2'h2 && !i_col_load && !i_host.strobe
        |=> $stable(o_col_addr); endproperty
    a_rd: assert property (p_rd) else $error("column moved on read");
    property p_end; o_rmw_active && cmd && v == 8'hEE && !i_col_load
        |=> !o_rmw_active && o_col_addr == saved; endproperty
    a_end: assert property (p_end) else $error("end did not restore");
    property p_pwr; s_par(8'h25) |=> o_cfg.power_en ==
        ($past(v[7:3]) == 5'h00 ? $past(v[2:0]) : $past(o_cfg.power_en)); endproperty
    a_pwr: assert property (p_pwr) else $error("power enables wrong");
endmodule : lcdcd_chk
bind lcdcd_top lcdcd_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_host(i_host),
    .i_ram(i_ram), .i_dummy_period(i_dummy_period), .i_col_load(i_col_load), .o_cfg(o_cfg),
    .o_display_lines(o_display_lines), .o_duty_div(o_duty_div), .o_rmw_active(o_rmw_active),
    .o_col_addr(o_col_addr), .o_segment_force_unlit(o_segment_force_unlit));

// >>> tb/lcdcd_top_tb.sv
`timescale 1ns/100ps
module lcdcd_top_tb;
    import lcdcd_pkg::*;
    logic           clk = 1'b0;
    logic           srst = 1'b1;
    logic           ms = 1'b0;
    logic           ios = 1'b0;
    logic           dummy = 1'b0;
    logic           cload = 1'b0;
    logic           rev = 1'b0;
    logic           step = 1'b0;
    logic [7:0]     cval = 8'h00;
    logic [6:0]     common_output;
    logic           extra;
    lcdcd_host_wr_t host;
    lcdcd_ram_acc_t ram = '0;
    lcdcd_cfg_t     cfg;
    lcdcd_cfg_t     ecfg;
    logic [6:0]     lines;
    logic [6:0]     duty;
    logic           rmw;
    logic [7:0]     col;
    logic           segment_output;
    int             num_errors = 0;
    int             n_checks = 0;
    // Clock of 4 ns period.
    always #2 clk = ~clk;
    // Host byte source and the decoder.
    lcdcd_host_model u_host (.i_clk(clk), .o_host(host));
    lcdcd_top uut (.i_clk(clk), .i_srst(srst), .i_host(host), .i_ram(ram),
        .i_master_strap(ms), .i_internal_osc_select_strap(ios), .i_scan_reverse(rev),
        .i_dummy_period(dummy), .i_line_step(step), .i_col_load(cload), .i_col_value(cval),
        .o_cfg(cfg), .o_display_lines(lines), .o_duty_div(duty), .o_rmw_active(rmw),
        .o_col_addr(col), .o_segment_force_unlit(segment_output), .o_common_line(common_output),
        .o_extra_common_line(extra));
    // Lets n edges pass and steps just past the last one.
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    // Compares one value and counts it.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    // Prints the counts and the verdict.
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // Reset state of every setting.
    task automatic t_reset();
        ecfg = '0;
        ecfg.line_code = 5'h13;
        chk("cfg", ecfg, cfg);
        chk("lines", 7'h51, lines);
        chk("duty", 7'h58, duty);
        chk("rmw", 0, rmw);
    endtask : t_reset
    // Inversion, display mode, dummy level and gray pattern.
    task automatic t_modes();
        u_host.cmd(8'hE5);
        chk("inv", 1, cfg.inv_on);
        u_host.cmd(8'hE4);
        chk("inv", 0, cfg.inv_on);
        dummy = 1'b1;
        u_host.cmd_par(8'h66, 8'h03);
        chk("mode", 3, {cfg.dummy_unlit, cfg.binary_mode});
        chk("seg", 1, segment_output);
        u_host.cmd_par(8'h66, 8'h00);
        chk("seg", 0, segment_output);
        u_host.cmd_par(8'h39, 8'h62);
        chk("gray", 6'h32, {cfg.gray_one_zero, cfg.gray_zero_one});
    endtask : t_modes
    // Line count and start block, including refused codes.
    task automatic t_lines(input logic [7:0] l, input logic [7:0] b, input logic [6:0] el,
                           input logic [4:0] eb);
        u_host.send(1'b0, 8'h6D);
        u_host.send(1'b1, l);
        u_host.send(1'b1, b);
        u_host.idle_bus();
        chk("lines", el, lines);
        chk("duty", el + 7'h07, duty);
        chk("block", eb, cfg.start_block);
    endtask : t_lines
    // Read-modify-write entry, access, end, and end outside the mode.
    task automatic t_rmw();
        cval  = 8'h10;
        cload = 1'b1;
        wait_cyc(1);
        cload = 1'b0;
        u_host.cmd(8'hE0);
        chk("rmw", 1, rmw);
        ram = '{1'b1, 1'b0};
        wait_cyc(1);
        ram = '{1'b0, 1'b1};
        wait_cyc(2);
        ram = '0;
        chk("col", 8'h12, col);
        u_host.cmd(8'hEE);
        chk("col", 8'h10, col);
        ram = '{1'b0, 1'b1};
        wait_cyc(1);
        ram = '0;
        u_host.cmd(8'hEE);
        chk("rmw_col", 9'h011, {rmw, col});
    endtask : t_rmw
    // Scan from the top block, wrap to line 0, extra line last, then reverse.
    task automatic t_scan();
        int k;
        u_host.send(1'b0, 8'h6D);
        u_host.send(1'b1, 8'h01);
        u_host.send(1'b1, 8'h13);
        u_host.idle_bus();
        chk("com", 7'h4C, common_output);
        step = 1'b1;
        for (k = 1; k < 9; k++)
        begin
            wait_cyc(1);
            chk("extra", (k == 8), extra);
            if (k < 8)
                chk("com", (k + 32'h4C) % 32'h50, common_output);
        end
        wait_cyc(1);
        step = 1'b0;
        chk("extra", 0, extra);
        chk("com", 7'h4C, common_output);
        rev = 1'b1;
        wait_cyc(1);
        chk("com", 7'h03, common_output);
        rev = 1'b0;
    endtask : t_scan
    // Oscillator gating by the straps, frequency and power sequence.
    task automatic t_osc();
        ms = 1'b1;
        u_host.cmd(8'hAB);
        chk("osc", 0, cfg.osc_on);
        ios = 1'b1;
        u_host.cmd(8'hAB);
        chk("osc", 1, cfg.osc_on);
        u_host.cmd_par(8'h25, 8'h07);
        u_host.cmd_par(8'h25, 8'h0C);
        chk("pwr", 7, cfg.power_en);
        u_host.cmd_par(8'h5F, 8'h0F);
        chk("freq", 4'hF, cfg.osc_freq);
        u_host.cmd_par(8'h25, 8'h00);
        u_host.cmd(8'hEB);
        u_host.cmd(8'hAA);
        chk("osc", 0, cfg.osc_on);
    endtask : t_osc
    // Watchdog against a hang.
    initial
    begin
        repeat (4000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    // Main sequence.
    initial
    begin
        wait_cyc(8);
        srst = 1'b0;
        t_reset();
        t_modes();
        t_lines(8'h00, 8'h13, 7'h05, 5'h13);
        t_lines(8'h14, 8'h14, 7'h05, 5'h13);
        t_lines(8'h12, 8'h00, 7'h4D, 5'h00);
        t_rmw();
        t_osc();
        t_scan();
        complete_run();
    end
endmodule : lcdcd_top_tb
